// File: rtl/rfs_pkg.sv
// constants for the rail fault supervisor
// Contract
// - current code = (monitor voltage - 0.8 V) / 0.8 V * 255.
// - monitor above 1.6 V past trigger delay latches overcurrent, all switches off.
// - per-phase limit = spike limit * strapped N / active phase count M.
// - forced single phase: per-phase check only during soft start.
// - per-phase trip turns off all switches of the rail.
// - after reset, sense above 1.85 V latches over-voltage; low on, high off.
// - over-voltage qualified for 1 ms before latching.
// - over- or under-voltage on one rail soft-stops the other rail.
// - sense 500 mV or more below reference latches under-voltage; all off. The code checks it in run state only.
// - under-voltage qualified for 3 ms before latching.
// - supply below reset threshold for 3 ms raises lockout, all off.
// - second rail disabled by sense pin high; its link commands rejected.
// - big load step beyond strapped threshold fires one pulse on all upper gates. The code fires it only in run state, on gate 0 alone in single phase.
package rfs_pkg;
  localparam int unsigned CLK_MHZ = 200;
  localparam int unsigned ADC_W = 10;
  // adc full scale 2.0 V over 1024 codes; codes are millivolt-scaled below
  localparam int unsigned ADC_FS_MV = 2000;
  localparam int unsigned MON_BASE_MV = 800;
  localparam int unsigned MON_SPAN_MV = 800;
  localparam int unsigned CODE_MAX = 255;
  localparam int unsigned SPIKE_MV = 1600;
  localparam int unsigned OVP_MV = 1850;
  localparam int unsigned UVP_MARGIN_MV = 500;
  localparam int unsigned OCP_DELAY_US = 10;
  localparam int unsigned OVP_DELAY_US = 1000;
  localparam int unsigned UVP_DELAY_US = 3000;
  localparam int unsigned SUPPLY_LOCKOUT_DELAY_US = 3000;
  localparam int unsigned SS_US = 1000;
  localparam int unsigned QR_PULSE_NS = 100;
  localparam int unsigned OCP_CYC = OCP_DELAY_US * CLK_MHZ;
  localparam int unsigned OVP_CYC = OVP_DELAY_US * CLK_MHZ;
  localparam int unsigned UVP_CYC = UVP_DELAY_US * CLK_MHZ;
  localparam int unsigned SUPPLY_LOCKOUT_CYC = SUPPLY_LOCKOUT_DELAY_US * CLK_MHZ;
  localparam int unsigned SS_CYC = SS_US * CLK_MHZ;
  localparam int unsigned QR_CYC = (QR_PULSE_NS * CLK_MHZ + 999) / 1000;
  // register offsets (byte addresses)
  localparam logic [3:0] REG_CODE = 4'h0;
  localparam logic [3:0] REG_STAT = 4'h4;
  localparam logic [3:0] REG_CTRL = 4'h8;
  // status bit positions
  localparam int unsigned ST_OCP = 0;
  localparam int unsigned ST_PER_PHASE_OVERCURRENT = 1;
  localparam int unsigned ST_OVP = 2;
  localparam int unsigned ST_UVP = 3;
  localparam int unsigned ST_SUPPLY_LOCKOUT = 4;
  localparam int unsigned ST_SS = 5;
  localparam int unsigned ST_R2DIS = 6;
  localparam int unsigned ST_REJ = 7;
  // control bit positions: quick response enable
  localparam int unsigned CT_QR_EN = 0;
  localparam logic [31:0] CTRL_RST = 32'h0000_0001;
  typedef enum logic [1:0] {RFS_OFF, RFS_SOFTSTART, RFS_RUN, RFS_SHUT} rfs_state_t;
endpackage

// File: rtl/rfs_top.sv
// rail fault supervisor: fault latches, current code, quick response, wishbone regs
//
// The Wishbone interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
module rfs_top #(
  parameter int unsigned OCP_CYC = rfs_pkg::OCP_CYC,
  parameter int unsigned OVP_CYC = rfs_pkg::OVP_CYC,
  parameter int unsigned UVP_CYC = rfs_pkg::UVP_CYC,
  parameter int unsigned SUPPLY_LOCKOUT_CYC = rfs_pkg::SUPPLY_LOCKOUT_CYC,
  parameter int unsigned SS_CYC = rfs_pkg::SS_CYC
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic reset_n_i,
  // adc samples in millivolts (asynchronous source)
  input wire logic [11:0] current_monitor_pin_i,
  input wire logic [11:0] output_sense_pin_i,
  input wire logic [11:0] reference_mv_i,
  input wire logic [11:0] phase1_current_mv_i,
  input wire logic [11:0] phase2_current_mv_i,
  input wire logic [11:0] load_step_mv_i,
  // comparator and strap pins
  input wire logic supply_below_por_i,
  input wire logic phase2_sense_pos_high_i,
  input wire logic rail2_sense_pos_high_i,
  input wire logic [2:0] offset_strap_pin_i,
  input wire logic [1:0] config_strap_one_i,
  input wire logic enable_i,
  // link command from the voltage link decoder
  input wire logic voltage_link_command_valid_i,
  input wire logic voltage_link_command_rail2_i,
  output logic voltage_link_command_accept_o,
  output logic voltage_link_command_reject_o,
  // gate drive
  output logic [1:0] upper_gate_drive_o,
  output logic [1:0] lower_gate_force_on_o,
  output logic all_switches_off_o,
  output logic quick_response_o,
  output logic rail2_soft_stop_o,
  output logic [7:0] current_report_code_o,
  // wishbone slave
  input wire logic [3:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o
);
  localparam int NIN = 6;
  logic [11:0] s1 [NIN];
  logic [11:0] s2 [NIN];
  logic [11:0] raw [NIN];
  logic [9:0] b1;
  logic [9:0] b2;
  logic [31:0] cnt_ocp, cnt_ovp, cnt_uvp, cnt_supply_lockout, cnt_ss;
  logic overcurrent_trip, per_phase_overcurrent, over_voltage_trip, under_voltage_trip, supply_lockout;
  logic [1:0] m_phases;
  logic [2:0] strap_n;
  logic [1:0] strap_qr;
  logic straps_taken;
  logic qr_en;
  logic [7:0] rej_cnt;
  logic [7:0] qr_cnt;
  logic qr_armed;
  rfs_pkg::rfs_state_t state;

  assign raw[0] = current_monitor_pin_i;
  assign raw[1] = output_sense_pin_i;
  assign raw[2] = reference_mv_i;
  assign raw[3] = phase1_current_mv_i;
  assign raw[4] = phase2_current_mv_i;
  assign raw[5] = load_step_mv_i;

  genvar g;
  generate
    for (g = 0; g < NIN; g++) begin : g_sync
      always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
          s1[g] <= 12'h000;
          s2[g] <= 12'h000;
        end else begin
          s1[g] <= raw[g];
          s2[g] <= s1[g];
        end
      end
    end
  endgenerate

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      b1 <= 10'h000;
      b2 <= 10'h000;
    end else begin
      b1 <= {offset_strap_pin_i, config_strap_one_i, supply_below_por_i,
             phase2_sense_pos_high_i, rail2_sense_pos_high_i, enable_i, 1'b1};
      b2 <= b1;
    end
  end

  wire below_por = b2[4];
  wire single_ph = b2[3];
  wire rail2_dis = b2[2];
  wire en_s = b2[1];

  // straps caught once, after the synchroniser has filled
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      straps_taken <= 1'b0;
      strap_n <= 3'h0;
      strap_qr <= 2'h0;
    end else if (!straps_taken && b2[0]) begin
      straps_taken <= 1'b1;
      strap_n <= b2[9:7];
      strap_qr <= b2[6:5];
    end
  end

  function automatic logic [7:0] mon_code(input logic [11:0] mv);
    logic [31:0] d;
    d = 32'h0;
    if (mv <= 12'(rfs_pkg::MON_BASE_MV)) begin
      mon_code = 8'h00;
    end else begin
      d = (32'(mv) - rfs_pkg::MON_BASE_MV) * rfs_pkg::CODE_MAX / rfs_pkg::MON_SPAN_MV;
      mon_code = (d > rfs_pkg::CODE_MAX) ? 8'hff : d[7:0];
    end
  endfunction

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      current_report_code_o <= 8'h00;
    end else begin
      current_report_code_o <= mon_code(s2[0]);
    end
  end

  // per-phase limit in monitor-relative millivolts: (1600-800)*(strap_n+1)/M
  assign m_phases = single_ph ? 2'd1 : 2'd2;
  wire [31:0] ph_lim = (rfs_pkg::SPIKE_MV - rfs_pkg::MON_BASE_MV) * (32'(strap_n) + 32'h1)
                       / 32'(m_phases);
  wire ocp_cond = 32'(s2[0]) > rfs_pkg::SPIKE_MV;
  wire ph_win = !single_ph || (state == rfs_pkg::RFS_SOFTSTART);
  wire ph_cond = ph_win && (32'(s2[3]) > ph_lim || (!single_ph && 32'(s2[4]) > ph_lim));
  wire ovp_cond = 32'(s2[1]) > rfs_pkg::OVP_MV;
  wire uvp_cond = (state == rfs_pkg::RFS_RUN) &&
                  32'(s2[1]) + rfs_pkg::UVP_MARGIN_MV <= 32'(s2[2]);

  // qualification timers restart on clear, latches hold until reset
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt_ocp <= 32'h0;
      cnt_ovp <= 32'h0;
      cnt_uvp <= 32'h0;
      cnt_supply_lockout <= 32'h0;
      overcurrent_trip <= 1'b0;
      per_phase_overcurrent <= 1'b0;
      over_voltage_trip <= 1'b0;
      under_voltage_trip <= 1'b0;
      supply_lockout <= 1'b0;
    end else begin
      cnt_ocp <= ocp_cond ? cnt_ocp + 32'h1 : 32'h0;
      cnt_ovp <= ovp_cond ? cnt_ovp + 32'h1 : 32'h0;
      cnt_uvp <= uvp_cond ? cnt_uvp + 32'h1 : 32'h0;
      cnt_supply_lockout <= below_por ? cnt_supply_lockout + 32'h1 : 32'h0;
      if (ocp_cond && cnt_ocp + 32'h1 >= OCP_CYC) overcurrent_trip <= 1'b1;
      if (ph_cond) per_phase_overcurrent <= 1'b1;
      if (ovp_cond && cnt_ovp + 32'h1 >= OVP_CYC) over_voltage_trip <= 1'b1;
      if (uvp_cond && cnt_uvp + 32'h1 >= UVP_CYC) under_voltage_trip <= 1'b1;
      if (below_por && cnt_supply_lockout + 32'h1 >= SUPPLY_LOCKOUT_CYC) supply_lockout <= 1'b1;
    end
  end

  wire any_fault = overcurrent_trip | per_phase_overcurrent | over_voltage_trip | under_voltage_trip | supply_lockout;

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state <= rfs_pkg::RFS_OFF;
      cnt_ss <= 32'h0;
    end else begin
      case (state)
        rfs_pkg::RFS_OFF: begin
          cnt_ss <= 32'h0;
          if (en_s && !any_fault) state <= rfs_pkg::RFS_SOFTSTART;
        end
        rfs_pkg::RFS_SOFTSTART: begin
          cnt_ss <= cnt_ss + 32'h1;
          if (any_fault) state <= rfs_pkg::RFS_SHUT;
          else if (cnt_ss + 32'h1 >= SS_CYC) state <= rfs_pkg::RFS_RUN;
        end
        rfs_pkg::RFS_RUN: begin
          if (any_fault) state <= rfs_pkg::RFS_SHUT;
        end
        default: begin
          state <= rfs_pkg::RFS_SHUT;
        end
      endcase
    end
  end

  // gate outputs: ovp holds low side on, others hold everything off
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      all_switches_off_o <= 1'b1;
      lower_gate_force_on_o <= 2'b00;
      rail2_soft_stop_o <= 1'b0;
    end else begin
      all_switches_off_o <= overcurrent_trip | per_phase_overcurrent | under_voltage_trip | supply_lockout | (state == rfs_pkg::RFS_OFF);
      lower_gate_force_on_o <= (over_voltage_trip && !(overcurrent_trip | per_phase_overcurrent | under_voltage_trip | supply_lockout)) ?
                               (single_ph ? 2'b01 : 2'b11) : 2'b00;
      rail2_soft_stop_o <= over_voltage_trip | under_voltage_trip;
    end
  end

  // quick response: one upper pulse per step event, on both upper gates in two-phase mode, on gate 0 alone in single phase
  wire [11:0] qr_th = 12'(32'(strap_qr) * 50 + 50);
  wire qr_cond = qr_en && (state == rfs_pkg::RFS_RUN) && !any_fault && s2[5] > qr_th;
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      qr_cnt <= 8'h00;
      qr_armed <= 1'b1;
      upper_gate_drive_o <= 2'b00;
      quick_response_o <= 1'b0;
    end else begin
      if (qr_cond && qr_armed) begin
        qr_cnt <= 8'(rfs_pkg::QR_CYC);
        qr_armed <= 1'b0;
      end else if (qr_cnt != 8'h00) begin
        qr_cnt <= qr_cnt - 8'h01;
      end
      if (!qr_cond) qr_armed <= 1'b1;
      quick_response_o <= (qr_cond && qr_armed) || qr_cnt > 8'h01;
      upper_gate_drive_o <= ((qr_cond && qr_armed) || qr_cnt > 8'h01) && !any_fault ?
                            (single_ph ? 2'b01 : 2'b11) : 2'b00;
    end
  end

  // link command acceptance
  assign voltage_link_command_reject_o = voltage_link_command_valid_i &&
                                         voltage_link_command_rail2_i && rail2_dis;
  assign voltage_link_command_accept_o = voltage_link_command_valid_i &&
                                         !voltage_link_command_reject_o;

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rej_cnt <= 8'h00;
    end else if (voltage_link_command_reject_o && rej_cnt != 8'hff) begin
      rej_cnt <= rej_cnt + 8'h01;
    end
  end

  // wishbone slave, one wait state, unmapped answers err
  wire req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= 32'h0;
      qr_en <= rfs_pkg::CTRL_RST[rfs_pkg::CT_QR_EN];
    end else begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      if (req) begin
        wb_dat_o <= 32'h0;
        if (wb_adr_i == rfs_pkg::REG_CODE) begin
          wb_ack_o <= 1'b1;
          wb_dat_o <= {24'h0, current_report_code_o};
        end else if (wb_adr_i == rfs_pkg::REG_STAT) begin
          wb_ack_o <= 1'b1;
          wb_dat_o <= {16'h0, rej_cnt, 1'b0, rail2_dis, state == rfs_pkg::RFS_SOFTSTART,
                       supply_lockout, under_voltage_trip, over_voltage_trip, per_phase_overcurrent, overcurrent_trip};
        end else if (wb_adr_i == rfs_pkg::REG_CTRL) begin
          wb_ack_o <= 1'b1;
          wb_dat_o <= {31'h0, qr_en};
          if (wb_we_i && wb_sel_i[0]) qr_en <= wb_dat_i[rfs_pkg::CT_QR_EN];
        end else begin
          wb_err_o <= 1'b1;
        end
      end
    end
  end

  property p_ovp_latch;
    @(posedge mclk_i) disable iff (!reset_n_i)
      (ovp_cond && cnt_ovp + 32'h1 >= OVP_CYC) |=> over_voltage_trip;
  endproperty
  a_ovp_latch: assert property (p_ovp_latch) else $error("ovp not latched");

  property p_uvp_early;
    @(posedge mclk_i) disable iff (!reset_n_i)
      $rose(under_voltage_trip) |-> $past(cnt_uvp) + 32'h1 >= UVP_CYC;
  endproperty
  a_uvp_early: assert property (p_uvp_early) else $error("uvp latched early");

  property p_hold;
    @(posedge mclk_i) disable iff (!reset_n_i) overcurrent_trip |=> overcurrent_trip;
  endproperty
  a_hold: assert property (p_hold) else $error("fault latch released");

  property p_off;
    @(posedge mclk_i) disable iff (!reset_n_i)
      (supply_lockout || overcurrent_trip || per_phase_overcurrent || under_voltage_trip) |=> all_switches_off_o && upper_gate_drive_o == 2'b00;
  endproperty
  a_off: assert property (p_off) else $error("switches not off");

  property p_ovp_low;
    @(posedge mclk_i) disable iff (!reset_n_i)
      (over_voltage_trip && !(overcurrent_trip | per_phase_overcurrent | under_voltage_trip | supply_lockout) && !single_ph) |=> lower_gate_force_on_o == 2'b11;
  endproperty
  a_ovp_low: assert property (p_ovp_low) else $error("low side not forced");

  property p_cross;
    @(posedge mclk_i) disable iff (!reset_n_i) (over_voltage_trip || under_voltage_trip) |=> rail2_soft_stop_o;
  endproperty
  a_cross: assert property (p_cross) else $error("other rail not stopped");

  property p_reject;
    @(posedge mclk_i) disable iff (!reset_n_i)
      (voltage_link_command_valid_i && voltage_link_command_rail2_i && rail2_dis)
        |-> !voltage_link_command_accept_o;
  endproperty
  a_reject: assert property (p_reject) else $error("rail2 command accepted");

  property p_code;
    @(posedge mclk_i) disable iff (!reset_n_i)
      (s2[0] <= 12'(rfs_pkg::MON_BASE_MV)) |=> current_report_code_o == 8'h00;
  endproperty
  a_code: assert property (p_code) else $error("code not zero at base");

  property p_ph_window;
    @(posedge mclk_i) disable iff (!reset_n_i)
      (single_ph && state == rfs_pkg::RFS_RUN) |-> !ph_cond;
  endproperty
  a_ph_window: assert property (p_ph_window) else $error("phase check late");
endmodule

// File: sim/rfs_far_model.sv
// far side model: cpu voltage link issuer with answer tallies
`timescale 1ns/100ps
module rfs_far_model (
  // clock and bench request
  input wire logic clk_i,
  input wire logic send_i,
  input wire logic send_rail2_i,
  // answer from the block
  input wire logic accept_i,
  input wire logic reject_i,
  // command to the block
  output logic valid_o = 1'b0,
  output logic rail2_o = 1'b0,
  // tallies
  output int acc_o = 0,
  output int rej_o = 0
);
  // one command per request, rail select toggles while idle
  always @(posedge clk_i) begin
    valid_o <= send_i;
    rail2_o <= send_i ? send_rail2_i : ~rail2_o;
    if (valid_o === 1'b1 && accept_i === 1'b1)
      acc_o <= acc_o + 1;
    if (valid_o === 1'b1 && reject_i === 1'b1)
      rej_o <= rej_o + 1;
  end
endmodule

// File: sim/rfs_top_test.sv
// self-checking bench for the rail fault supervisor
`timescale 1ns/100ps
module rfs_top_test;
  localparam int OVERCURRENT_TRIP = 20, OVER_VOLTAGE_TRIP = 30, UNDER_VOLTAGE_TRIP = 40, ULO = 40, SS = 60;
  logic clk = 1'b0, rst_n = 1'b0;
  logic [11:0] current_monitor_pin = 12'h320, output_sense_pin = 12'h4b0, vref = 12'h4b0;
  logic [11:0] ph1 = 12'h0, ph2 = 12'h0, stp = 12'h0;
  logic below = 1'b0, ph2hi = 1'b0, r2hi = 1'b0, en = 1'b0;
  logic [2:0] ostrap = 3'h0;
  logic [1:0] cstrap = 2'h0;
  logic send = 1'b0, send2 = 1'b0, lv, lr2, acc, rej;
  logic alloff, qr, r2ss, ack, werr, e, seen;
  logic we = 1'b0, cyc = 1'b0, stb = 1'b0;
  logic [1:0] ug, lg, g;
  logic [7:0] code;
  logic [3:0] adr = 4'h0;
  logic [31:0] wdat = 32'h0, rdat, q;
  logic [11:0] mv [5] = '{12'h2bc, 12'h320, 12'h460, 12'h640, 12'h7d0};
  logic [7:0] cd [5] = '{8'h0, 8'h0, 8'h66, 8'hff, 8'hff};
  int err_count = 0, tests_run = 0, nacc, nrej, n, b, lim;

  rfs_top #(.OCP_CYC(OVERCURRENT_TRIP), .OVP_CYC(OVER_VOLTAGE_TRIP), .UVP_CYC(UNDER_VOLTAGE_TRIP), .SUPPLY_LOCKOUT_CYC(ULO), .SS_CYC(SS)) uut (
    .mclk_i(clk), .reset_n_i(rst_n), .current_monitor_pin_i(current_monitor_pin),
    .output_sense_pin_i(output_sense_pin), .reference_mv_i(vref), .phase1_current_mv_i(ph1),
    .phase2_current_mv_i(ph2), .load_step_mv_i(stp), .supply_below_por_i(below),
    .phase2_sense_pos_high_i(ph2hi), .rail2_sense_pos_high_i(r2hi),
    .offset_strap_pin_i(ostrap), .config_strap_one_i(cstrap), .enable_i(en),
    .voltage_link_command_valid_i(lv), .voltage_link_command_rail2_i(lr2),
    .voltage_link_command_accept_o(acc), .voltage_link_command_reject_o(rej),
    .upper_gate_drive_o(ug), .lower_gate_force_on_o(lg), .all_switches_off_o(alloff),
    .quick_response_o(qr), .rail2_soft_stop_o(r2ss), .current_report_code_o(code),
    .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(4'h1), .wb_we_i(we), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(werr)
  );
  rfs_far_model far (.clk_i(clk), .send_i(send), .send_rail2_i(send2), .accept_i(acc),
    .reject_i(rej), .valid_o(lv), .rail2_o(lr2), .acc_o(nacc), .rej_o(nrej));

  initial begin
    forever #2.5 clk = ~clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask
  task automatic tick(input int c);
    repeat (c) @(posedge clk);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic wb(input logic [3:0] a, input logic w, input logic [31:0] d);
    @(posedge clk);
    adr <= a;
    we <= w;
    wdat <= d;
    cyc <= 1'b1;
    stb <= 1'b1;
    do @(posedge clk); while (ack !== 1'b1 && werr !== 1'b1);
    q = rdat;
    e = werr;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic st(input int bit_pos, input logic v, input string m);
    wb(rfs_pkg::REG_STAT, 1'b0, 32'h0);
    chk(32'(q[bit_pos]), 32'(v), m);
  endtask
  task automatic rst(input logic go);
    rst_n <= 1'b0;
    current_monitor_pin <= 12'h320;
    output_sense_pin <= 12'h4b0;
    ph1 <= 12'h0;
    stp <= 12'h0;
    below <= 1'b0;
    en <= 1'b0;
    tick(16);
    rst_n <= 1'b1;
    tick(2);
    if (go) begin
      en <= 1'b1;
      tick(SS + 8);
    end
  endtask
  // fault stimulus: off value sits exactly on the overcurrent and over-voltage thresholds, one millivolt above the under-voltage one
  task automatic drive(input int k, input logic on);
    if (k == 0) current_monitor_pin <= on ? 12'h641 : 12'h640;
    if (k == 1) output_sense_pin <= on ? 12'h73b : 12'h73a;
    if (k == 2) output_sense_pin <= on ? 12'h2bc : 12'h2bd;
    if (k == 3) below <= on;
  endtask
  task automatic ph_case(input logic [2:0] s, input logic one, input logic ss, input logic tr);
    ostrap <= s;
    ph2hi <= one;
    rst(1'b0);
    en <= 1'b1;
    tick(ss ? 8 : SS + 8);
    lim = 800 * (s + 1) / (one ? 1 : 2);
    ph1 <= 12'(lim);
    tick(6);
    st(rfs_pkg::ST_PER_PHASE_OVERCURRENT, 1'b0, "phase at limit");
    ph1 <= 12'(lim + 1);
    tick(6);
    st(rfs_pkg::ST_PER_PHASE_OVERCURRENT, tr, "phase over limit");
    chk(alloff, tr, "phase trip off");
  endtask
  task automatic watch(input int c);
    seen = 1'b0;
    g = 2'h0;
    repeat (c) begin
      @(posedge clk);
      seen = seen | (qr === 1'b1);
      g = g | ug;
    end
  endtask
  task automatic link(input logic r2);
    send <= 1'b1;
    send2 <= r2;
    tick(1);
    send <= 1'b0;
    tick(2);
  endtask

  initial begin
    tick(20000);
    err_count++;
    $display("CHECK FAILED %0t timeout", $time);
    wrap_up();
  end

  initial begin
    rst(1'b0);
    chk(alloff, 1'b1, "off after reset");
    wb(rfs_pkg::REG_STAT, 1'b0, 32'h0);
    chk(q, 32'h0, "status reset");
    wb(rfs_pkg::REG_CTRL, 1'b0, 32'h0);
    chk(q, rfs_pkg::CTRL_RST, "ctrl reset");
    wb(4'hc, 1'b0, 32'h0);
    chk(e, 1'b1, "unmapped");
    wb(rfs_pkg::REG_CODE, 1'b1, 32'hff);
    wb(rfs_pkg::REG_CODE, 1'b0, 32'h0);
    chk(q, 32'h0, "code read only");
    for (int i = 0; i < 5; i++) begin
      current_monitor_pin <= mv[i];
      tick(6);
      chk(code, cd[i], "code pin");
      wb(rfs_pkg::REG_CODE, 1'b0, 32'h0);
      chk(q, 32'(cd[i]), "code reg");
    end
    for (int k = 0; k < 4; k++) begin
      n = (k == 0) ? OVERCURRENT_TRIP : (k == 1) ? OVER_VOLTAGE_TRIP : (k == 2) ? UNDER_VOLTAGE_TRIP : ULO;
      b = (k == 0) ? rfs_pkg::ST_OCP : (k == 1) ? rfs_pkg::ST_OVP : k + 1;
      rst(1'b1);
      drive(k, 1'b0);
      tick(n + 10);
      drive(k, 1'b1);
      tick(n - 5);
      drive(k, 1'b0);
      tick(4);
      drive(k, 1'b1);
      tick(n - 5);
      drive(k, 1'b0);
      st(b, 1'b0, "no early latch");
      drive(k, 1'b1);
      tick(n + 10);
      st(b, 1'b1, "fault latched");
      if (k == 1) begin
        chk(lg, 2'h3, "low side on");
        chk(ug, 2'h0, "high side off");
      end else begin
        chk(alloff, 1'b1, "switches off");
      end
      chk(r2ss, 32'(k == 1 || k == 2), "other rail stop");
      drive(k, 1'b0);
      tick(10);
      st(b, 1'b1, "fault held");
    end
    ph_case(3'h0, 1'b0, 1'b0, 1'b1);
    ph_case(3'h3, 1'b0, 1'b0, 1'b1);
    ph_case(3'h1, 1'b1, 1'b1, 1'b1);
    ph_case(3'h1, 1'b1, 1'b0, 1'b0);
    // back to two phases so both upper gates take the pulse
    ph2hi <= 1'b0;
    for (int v = 0; v < 4; v++) begin
      cstrap <= 2'(v);
      rst(1'b1);
      stp <= 12'(50 + 50 * v);
      watch(12);
      chk(seen, 1'b0, "no pulse at threshold");
      stp <= 12'(51 + 50 * v);
      watch(30);
      chk(seen, 1'b1, "pulse over threshold");
      chk(g, 2'h3, "all upper gates");
    end
    wb(rfs_pkg::REG_CTRL, 1'b1, 32'h0);
    wb(rfs_pkg::REG_CTRL, 1'b0, 32'h0);
    chk(q, 32'h0, "ctrl write");
    r2hi <= 1'b1;
    rst(1'b1);
    link(1'b0);
    link(1'b1);
    link(1'b1);
    chk(nacc, 32'h1, "rail one accepted");
    chk(nrej, 32'h2, "rail two rejected");
    wb(rfs_pkg::REG_STAT, 1'b0, 32'h0);
    chk(q[15:8], 32'h2, "reject count");
    chk(q[rfs_pkg::ST_R2DIS], 1'b1, "rail two off");
    r2hi <= 1'b0;
    rst(1'b1);
    link(1'b1);
    chk(nacc, 32'h2, "rail two accepted");
    wrap_up();
  end
endmodule
